// File: src/ers_pkg.sv
// Shared constants for the event raster sampler.
package ers_pkg;
  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NCH        = 4;          // Input channels that are sampled.
  localparam int NDI        = 4;          // Digital inputs usable as sources.
  localparam int NEV        = 4;          // Configurable trigger events.
  localparam int DW         = 16;         // Width of one measured value.
  localparam int CHW        = 2;          // Width of a channel index.
  localparam int REC_W      = CHW + DW;   // Sample record: index and value.
  localparam int FIFO_DEPTH = 32;         // Records held in the output FIFO.
  localparam int CNTW       = 8;          // Width of a cycle period count.
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_NS     = 10;         // Clock period in ns.
  localparam int GLITCH_NS  = 120;        // Shortest accepted pulse in ns.
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int UPDATE_MS  = 300;        // Output update interval in ms.
  localparam int UPDATE_CYC = UPDATE_MS * (1000000 / CLK_NS);
  // ----------------------------------------------------------------------
  // Event firing conditions
  // ----------------------------------------------------------------------
  localparam logic [1:0] COND_FALL  = 2'h0; // Active-to-inactive edge.
  localparam logic [1:0] COND_RISE  = 2'h1; // Inactive-to-active edge.
  localparam logic [1:0] COND_BOTH  = 2'h2; // Either edge.
  localparam logic [1:0] COND_CYCLE = 2'h3; // End of a cycle of n periods.
  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [DW-1:0]  RST_VALUE = 16'h0000;
  localparam logic [31:0]    RST_COUNT = 32'h0000_0000;
endpackage

// File: src/ers_sampler.sv
// Event raster sampler: input filters, event unit, sampler, FIFO, output stage.
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------------------
// Record FIFO
// --------------------------------------------------------------------------
// Flip-flop FIFO with valid/ready on both sides; full drops in_ready.
module ers_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_q [DEPTH];      // Storage words.
  logic [AW-1:0] wr_q, wr_d;         // Write index.
  logic [AW-1:0] rd_q, rd_d;         // Read index.
  logic [AW:0]   cnt_q, cnt_d;       // Words held.
  logic          push, pop;

  // Full and empty come straight from the fill count.
  always_comb begin
    in_ready  = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    out_data  = mem_q[rd_q];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_d      = push ? wr_q + 1'b1 : wr_q;
    rd_d      = pop ? rd_q + 1'b1 : rd_q;
    cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Pointers reset; the storage itself needs no reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule

// --------------------------------------------------------------------------
// Top level
// --------------------------------------------------------------------------
module ers_sampler
  import ers_pkg::*;
#(
  parameter int UPDATE_CYCLES = UPDATE_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [NDI-1:0]     di_in,
  input  wire logic [NCH*DW-1:0]  ch_data,
  input  wire logic [NCH-1:0]     ch_fresh,
  input  wire logic [NCH-1:0]     ch_event_mode,
  input  wire logic [15:0]        raster_period,
  input  wire logic [NEV-1:0]     ev_enable,
  input  wire logic [NEV*2-1:0]   ev_src,
  input  wire logic [NEV*2-1:0]   ev_cond,
  input  wire logic [NEV*CNTW-1:0] ev_cycle_n,
  input  wire logic               stim_valid,
  input  wire logic [DW-1:0]      stim_data,
  input  wire logic               smp_ready,
  output logic                    smp_valid,
  output logic [REC_W-1:0]        smp_data,
  output logic [DW-1:0]           stim_out,
  output logic                    stim_update,
  output logic [NDI-1:0]          di_level,
  output logic [NEV-1:0]          event_fired
);
  // ------------------------------------------------------------------------
  // Input filters
  // ------------------------------------------------------------------------
  logic [NDI-1:0] sync1_q, sync2_q;           // Two-stage synchroniser.
  logic [NDI-1:0] lvl_q, lvl_d;               // Filtered level, 1 = active.
  logic [NDI-1:0] prev_q;                     // Filtered level, one cycle late.
  logic [3:0]     gcnt_q [NDI];               // Stability counters.
  logic [3:0]     gcnt_d [NDI];
  logic [NDI-1:0] rise, fall;

  // A level is accepted only after it stood for the shortest pulse width,
  // so a spike never reaches the event unit and each edge counts once.
  always_comb begin
    for (int i = 0; i < NDI; i++) begin
      lvl_d[i]  = lvl_q[i];
      gcnt_d[i] = 4'h0;
      if (sync2_q[i] != lvl_q[i]) begin
        if (gcnt_q[i] == 4'(GLITCH_CYC - 1)) begin
          lvl_d[i] = sync2_q[i];
        end else begin
          gcnt_d[i] = gcnt_q[i] + 4'h1;
        end
      end
    end
    rise = lvl_q & ~prev_q;
    fall = ~lvl_q & prev_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      lvl_q   <= '0;
      prev_q  <= '0;
      for (int i = 0; i < NDI; i++) begin
        gcnt_q[i] <= 4'h0;
      end
    end else begin
      sync1_q <= di_in;
      sync2_q <= sync1_q;
      lvl_q   <= lvl_d;
      prev_q  <= lvl_q;
      for (int i = 0; i < NDI; i++) begin
        gcnt_q[i] <= gcnt_d[i];
      end
    end
  end

  // ------------------------------------------------------------------------
  // Event unit
  // ------------------------------------------------------------------------
  logic [NEV-1:0]  fire_q, fire_d;            // Event fired last cycle.
  logic [CNTW-1:0] cyc_q [NEV];               // Periods seen in this cycle.
  logic [CNTW-1:0] cyc_d [NEV];
  logic [1:0]      src;
  logic [CNTW-1:0] need;

  // A cycle is counted in periods bounded by rising edges; n of 0 acts as 1.
  always_comb begin
    src  = 2'h0;
    need = '0;
    for (int e = 0; e < NEV; e++) begin
      src       = ev_src[e*2 +: 2];
      need      = (ev_cycle_n[e*CNTW +: CNTW] == '0) ? CNTW'(1)
                                                     : ev_cycle_n[e*CNTW +: CNTW];
      fire_d[e] = 1'b0;
      cyc_d[e]  = cyc_q[e];
      if (ev_enable[e]) begin
        case (ev_cond[e*2 +: 2])
          COND_FALL: fire_d[e] = fall[src];
          COND_RISE: fire_d[e] = rise[src];
          COND_BOTH: fire_d[e] = rise[src] | fall[src];
          default: begin
            if (rise[src]) begin
              if (cyc_q[e] + CNTW'(1) >= need) begin
                fire_d[e] = 1'b1;
                cyc_d[e]  = '0;
              end else begin
                cyc_d[e] = cyc_q[e] + CNTW'(1);
              end
            end
          end
        endcase
      end else begin
        cyc_d[e] = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fire_q <= '0;
      for (int e = 0; e < NEV; e++) begin
        cyc_q[e] <= '0;
      end
    end else begin
      fire_q <= fire_d;
      for (int e = 0; e < NEV; e++) begin
        cyc_q[e] <= cyc_d[e];
      end
    end
  end

  // ------------------------------------------------------------------------
  // Sampler
  // ------------------------------------------------------------------------
  logic [15:0]     rast_q, rast_d;            // Raster divider.
  logic            tick_q, tick_d;            // Raster instant.
  logic [DW-1:0]   held_q [NCH];              // Last valid value per channel.
  logic [DW-1:0]   held_d [NCH];
  logic [DW-1:0]   snap_q [NCH];              // Value taken at the request.
  logic [DW-1:0]   snap_d [NCH];
  logic [NCH-1:0]  pend_q, pend_d;            // Request not yet queued.
  logic [NCH-1:0]  req, pop;
  logic            ev_any, fifo_in_ready, fifo_in_valid;
  logic [CHW-1:0]  sel;
  logic [REC_W-1:0] fifo_in_data;

  // A new request on a channel that still waits is merged into it, since
  // the waiting one must be finished first; back-pressure lands here.
  always_comb begin
    tick_d = (rast_q >= raster_period - 16'h0001);
    rast_d = tick_d ? 16'h0000 : rast_q + 16'h0001;
    ev_any = |fire_q;
    sel    = '0;
    fifo_in_valid = |pend_q;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (pend_q[c]) begin
        sel = CHW'(c);
      end
    end
    pop          = fifo_in_ready ? (NCH'(1) << sel) & pend_q : '0;
    fifo_in_data = {sel, snap_q[sel]};
    for (int c = 0; c < NCH; c++) begin
      req[c]    = (tick_q & ~ch_event_mode[c]) | ev_any;
      held_d[c] = ch_fresh[c] ? ch_data[c*DW +: DW] : held_q[c];
      snap_d[c] = snap_q[c];
      if (req[c] && (!pend_q[c] || pop[c])) begin
        snap_d[c] = held_q[c];
      end
      pend_d[c] = (pend_q[c] & ~pop[c]) | req[c];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rast_q <= 16'h0000;
      tick_q <= 1'b0;
      pend_q <= '0;
      for (int c = 0; c < NCH; c++) begin
        held_q[c] <= RST_VALUE;
        snap_q[c] <= RST_VALUE;
      end
    end else begin
      rast_q <= rast_d;
      tick_q <= tick_d;
      pend_q <= pend_d;
      for (int c = 0; c < NCH; c++) begin
        held_q[c] <= held_d[c];
        snap_q[c] <= snap_d[c];
      end
    end
  end

  // ------------------------------------------------------------------------
  // Record FIFO and registered output stage
  // ------------------------------------------------------------------------
  logic             fifo_out_valid, fifo_out_ready;
  logic [REC_W-1:0] fifo_out_data;
  logic             smp_valid_q, smp_valid_d;
  logic [REC_W-1:0] smp_data_q, smp_data_d;

  ers_fifo #(.W(REC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // The output register refills whenever it is empty or being taken.
  always_comb begin
    fifo_out_ready = !smp_valid_q || smp_ready;
    smp_valid_d    = fifo_out_ready ? fifo_out_valid : smp_valid_q;
    smp_data_d     = (fifo_out_ready && fifo_out_valid) ? fifo_out_data : smp_data_q;
  end

  // ------------------------------------------------------------------------
  // Stimulation output
  // ------------------------------------------------------------------------
  logic [31:0]   upd_q, upd_d;                // Update interval counter.
  logic          spend_q, spend_d;            // Newest value waiting.
  logic [DW-1:0] sbuf_q, sbuf_d;
  logic [DW-1:0] sout_q, sout_d;
  logic          supd_q, supd_d;

  // Values arriving between updates overwrite each other; only the last one
  // is applied. The output never moves without a received value.
  always_comb begin
    upd_d   = (upd_q == 32'(UPDATE_CYCLES - 1)) ? RST_COUNT : upd_q + 32'h0000_0001;
    spend_d = spend_q;
    sbuf_d  = sbuf_q;
    sout_d  = sout_q;
    supd_d  = 1'b0;
    if (stim_valid) begin
      spend_d = 1'b1;
      sbuf_d  = stim_data;
    end
    if (upd_q == 32'(UPDATE_CYCLES - 1) && spend_q) begin
      sout_d = sbuf_q;
      supd_d = 1'b1;
      if (!stim_valid) begin
        spend_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      smp_valid_q <= 1'b0;
      smp_data_q  <= '0;
      upd_q       <= RST_COUNT;
      spend_q     <= 1'b0;
      sbuf_q      <= RST_VALUE;
      sout_q      <= RST_VALUE;
      supd_q      <= 1'b0;
    end else begin
      smp_valid_q <= smp_valid_d;
      smp_data_q  <= smp_data_d;
      upd_q       <= upd_d;
      spend_q     <= spend_d;
      sbuf_q      <= sbuf_d;
      sout_q      <= sout_d;
      supd_q      <= supd_d;
    end
  end

  assign smp_valid   = smp_valid_q;
  assign smp_data    = smp_data_q;
  assign stim_out    = sout_q;
  assign stim_update = supd_q;
  assign di_level    = lvl_q;
  assign event_fired = fire_q;

  // ------------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ev_rise_fire_a: assert property (ev_enable[0] && ev_cond[1:0] == COND_RISE
    && rise[ev_src[1:0]] |=> fire_q[0]) else $error("rise event missed");
  ev_gate_a: assert property ($rose(pend_q[0]) && $past(ch_event_mode[0])
    |-> $past(fire_q != '0)) else $error("event channel sampled without event");
  all_capture_a: assert property ((fire_q != '0) && pend_q == '0
    |=> pend_q == '1) else $error("event did not capture all channels");
  raster_req_a: assert property (tick_q && !ch_event_mode[0] && !pend_q[0]
    |=> pend_q[0]) else $error("raster instant not taken");
  pend_hold_a: assert property (pend_q[0] && !pop[0]
    |=> pend_q[0] && $stable(snap_q[0])) else $error("pending request disturbed");
  held_value_a: assert property (!ch_fresh[0] |=> held_q[0] == $past(held_q[0]))
    else $error("held value changed without fresh data");
  stim_only_a: assert property (!spend_q ##1 !spend_q
    |-> $stable(sout_q)) else $error("output changed without value");
  stim_newest_a: assert property (stim_valid
    |=> spend_q && sbuf_q == $past(stim_data)) else $error("newest value lost");
endmodule

`default_nettype wire

// File: verification/ers_master_model.sv
// Measurement master model that takes sample records from the sampler.
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------------------
// Record sink
// --------------------------------------------------------------------------
module ers_master_model
  import ers_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             stall,
  input  wire logic             slow,
  input  wire logic             smp_valid,
  input  wire logic [REC_W-1:0] smp_data,
  output logic                  smp_ready,
  output logic                  overload
);
  logic [REC_W-1:0] q[$];  // Records taken, oldest first.
  logic             tgl;   // Pace toggle; slow mode takes every other cycle.

  // Ready moves by non-blocking assignment on the rising edge, so the
  // sampler sees it settled and the bench's falling-edge pace inputs never
  // race it.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl       <= 1'b0;
      smp_ready <= 1'b0;
    end else begin
      tgl       <= ~tgl;
      smp_ready <= !stall && (!slow || tgl);
    end
  end

  // A record is taken at the rising edge that sees valid and ready high.
  // The overload flag rises when records pile up far beyond one burst.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overload <= 1'b0;
    end else begin
      if (smp_valid && smp_ready) begin
        q.push_back(smp_data);
      end
      overload <= (q.size() > 64);
    end
  end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking testbench for the event raster sampler.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_val(64'(g), 64'(e))

module testbench
  import ers_pkg::*;
;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic               clk, rst_n, stall, slow;   // Clock, reset, sink pace.
  logic [NDI-1:0]     di_in;                     // Digital input levels.
  logic [NCH*DW-1:0]  ch_data;                   // Channel values.
  logic [NCH-1:0]     ch_fresh, ch_event_mode;   // Fresh pulses, modes.
  logic [15:0]        raster_period;             // Raster interval.
  logic [NEV-1:0]     ev_enable, event_fired;    // Event control and pulses.
  logic [NEV*2-1:0]   ev_src, ev_cond;           // Event source and condition.
  logic [NEV*CNTW-1:0] ev_cycle_n;               // Periods per cycle.
  logic               stim_valid, stim_update;   // Stimulation strobes.
  logic [DW-1:0]      stim_data, stim_out;       // Stimulation values.
  logic               smp_ready, smp_valid;      // Record handshake.
  logic [REC_W-1:0]   smp_data;                  // Record payload.
  logic [NDI-1:0]     di_level;                  // Filtered levels.
  logic               overload;                  // Sink overload flag.
  int                 bad_count, check_count;    // Result counters.

  // A short update interval keeps the stimulation scenario brief.
  ers_sampler #(.UPDATE_CYCLES(20)) DUT (.clk(clk), .rst_n(rst_n), .di_in(di_in),
    .ch_data(ch_data), .ch_fresh(ch_fresh), .ch_event_mode(ch_event_mode),
    .raster_period(raster_period), .ev_enable(ev_enable), .ev_src(ev_src),
    .ev_cond(ev_cond), .ev_cycle_n(ev_cycle_n), .stim_valid(stim_valid),
    .stim_data(stim_data), .smp_ready(smp_ready), .smp_valid(smp_valid),
    .smp_data(smp_data), .stim_out(stim_out), .stim_update(stim_update),
    .di_level(di_level), .event_fired(event_fired));

  ers_master_model sink (.clk(clk), .rst_n(rst_n), .stall(stall), .slow(slow),
    .smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready),
    .overload(overload));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Compares with case equality so an unknown never passes.
  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Loads value base+c into every channel with one fresh pulse.
  task automatic load_vals(input logic [15:0] base);
    for (int c = 0; c < NCH; c++) begin
      ch_data[c*DW+:DW] = base + 16'(c);
    end
    ch_fresh = 4'hF;
    @(negedge clk);
    ch_fresh = 4'h0;
  endtask

  // Waits, bounded, until the sink holds n records; a lapse ends the run.
  task automatic wait_recs(input int n);
    int k;
    k = 0;
    while (sink.q.size() < n && k < 300) begin
      @(negedge clk);
      k++;
    end
    if (sink.q.size() < n) begin
      bad_count++;
      finish_test();
    end
  endtask

  // Checks groups of all-channel records, each channel c holding base+c.
  task automatic check_groups(input int groups, input logic [15:0] base);
    wait_recs(groups * NCH);
    for (int g = 0; g < groups * NCH; g++) begin
      `CHK(sink.q.pop_front(), {2'(g % NCH), base + 16'(g % NCH)});
    end
    `CHK(sink.q.size(), 0);
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  // Every event, each on another input and condition, over two pulses.
  task automatic s_conditions();
    logic [1:0] cond_tab[4] = '{COND_FALL, COND_RISE, COND_BOTH, COND_CYCLE};
    int         exp_tab[4]  = '{2, 2, 4, 1};
    int         hits;
    load_vals(16'h1000);
    for (int e = 0; e < NEV; e++) begin
      ev_src[e*2+:2]    = 2'(3 - e);       // Source differs per event.
      ev_cond[e*2+:2]   = cond_tab[e];
      ev_cycle_n[e*8+:8] = 8'h02;          // Two periods make a cycle.
      ev_enable         = 4'(1 << e);
      hits              = 0;
      repeat (2) begin
        di_in[3-e] = 1'b1;
        repeat (25) begin
          @(negedge clk);
          hits += int'(event_fired[e]);
        end
        `CHK(di_level[3-e], 1);
        di_in[3-e] = 1'b0;
        repeat (25) begin
          @(negedge clk);
          hits += int'(event_fired[e]);
        end
      end
      `CHK(hits, exp_tab[e]);
      check_groups(exp_tab[e], 16'h1000);
    end
  endtask

  // A pulse shorter than the filter must leave no trace; the rise that
  // follows it exercises the rising-edge condition on event 0.
  task automatic s_glitch();
    ev_src = 8'h00;
    ev_cond = {4{COND_RISE}};
    ev_enable = 4'h1;
    load_vals(16'h3000);
    di_in[0] = 1'b1;
    repeat (8) @(negedge clk);
    di_in[0] = 1'b0;
    repeat (30) @(negedge clk);
    `CHK(di_level, 0);
    `CHK(sink.q.size(), 0);
    di_in[0] = 1'b1;
    repeat (30) @(negedge clk);
    check_groups(1, 16'h3000);
  endtask

  // Only the raster channel samples on ticks; the others wait for events.
  task automatic s_raster();
    int n;
    ev_enable = 4'h0;
    load_vals(16'h2000);
    raster_period = 16'd40;
    ch_event_mode = 4'b1101;
    repeat (200) @(negedge clk);
    ch_event_mode = 4'hF;
    repeat (10) @(negedge clk);
    n = sink.q.size();
    `CHK(n >= 4 && n <= 6, 1);
    repeat (n) `CHK(sink.q.pop_front(), {2'd1, 16'h2001});
  endtask

  // Fill the FIFO with the sink stalled, then drain it at a slow pace.
  task automatic s_fifo();
    int k;
    logic [REC_W-1:0] held;
    stall = 1'b1;
    slow = 1'b1;
    raster_period = 16'd1;
    ch_event_mode = 4'b1110;
    repeat (100) @(negedge clk);
    held = smp_data;
    ch_event_mode = 4'hF;
    repeat (5) @(negedge clk);
    `CHK(smp_valid, 1);
    `CHK(smp_data, held);
    stall = 1'b0;
    k = 0;
    while (smp_valid === 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    `CHK(smp_valid, 0);
    `CHK(sink.q.size() >= FIFO_DEPTH && sink.q.size() <= FIFO_DEPTH + 3, 1);
    `CHK(sink.q[0], {2'd0, 16'h2000});
    `CHK(overload, 0);
    sink.q.delete();
    slow = 1'b0;
  endtask

  // Two values between updates: only the newest reaches the output.
  task automatic s_stim();
    int k;
    int ups;
    `CHK(stim_out, 0);
    stim_data = 16'hA5A5;
    stim_valid = 1'b1;
    @(negedge clk);
    stim_data = 16'h5A5A;
    @(negedge clk);
    stim_valid = 1'b0;
    k = 0;
    while (stim_update !== 1'b1 && k < 60) begin
      @(negedge clk);
      k++;
    end
    `CHK(stim_update, 1);
    `CHK(stim_out, 16'h5A5A);
    ups = 0;
    repeat (60) begin
      @(negedge clk);
      ups += int'(stim_update);
    end
    `CHK(ups, 0);
    `CHK(stim_out, 16'h5A5A);
  endtask

  // --------------------------------------------------------------------------
  // Clock, reset and main sequence
  // --------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // A hang is cut short here and counted as a mismatch.
  initial begin
    #500us;
    bad_count++;
    finish_test();
  end

  initial begin
    bad_count = 0;
    check_count = 0;
    rst_n = 1'b0;
    {stall, slow, stim_valid} = 3'b000;
    di_in = 4'h0;
    ch_data = '0;
    ch_fresh = 4'h0;
    ch_event_mode = 4'hF;  // Event mode everywhere until a scenario says not.
    raster_period = 16'd100;
    {ev_enable, ev_src, ev_cond, ev_cycle_n} = '0;
    stim_data = 16'h0000;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    s_stim();
    s_conditions();
    s_glitch();
    s_raster();
    s_fifo();
    finish_test();
  end
endmodule
`default_nettype wire
